// ==== src/lms_pkg.sv ====
package lms_pkg;

  // ----------------------------------------
  // Opcodes handled by this datapath slice
  // ----------------------------------------
  localparam logic [7:0] OP_MULTIPLY_PAIR = 8'hF4;
  localparam logic [7:0] OP_OR_FIRST      = 8'h42;
  localparam logic [7:0] OP_OR_LAST       = 8'h47;
  localparam logic [7:0] OP_OR_EXT_FIRST  = 8'h48;
  localparam logic [7:0] OP_OR_EXT_LAST   = 8'h49;
  localparam logic [7:0] OP_XOR_FIRST     = 8'hB2;
  localparam logic [7:0] OP_XOR_LAST      = 8'hB7;
  localparam logic [7:0] OP_XOR_EXT_FIRST = 8'hB8;
  localparam logic [7:0] OP_XOR_EXT_LAST  = 8'hB9;
  localparam logic [7:0] OP_POP_DIRECT    = 8'h50;
  localparam logic [7:0] OP_POP_INDIRECT  = 8'h51;

  // ----------------------------------------
  // Flag byte layout: C Z S V D H
  // ----------------------------------------
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [11:0] SP_RESET    = 12'h000;

  typedef enum logic [1:0] {
    LMS_OP_NONE = 2'b00,
    LMS_OP_MUL  = 2'b01,
    LMS_OP_LOG  = 2'b10,
    LMS_OP_POP  = 2'b11
  } lms_op_e;

endpackage : lms_pkg

// ==== src/lms_exec.sv ====
`timescale 1ns/100ps
module lms_exec
  import lms_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Instruction issue from the decoder
  input  wire logic        issueValid,
  input  wire logic [7:0]  opcode,
  input  wire logic [15:0] dstValue,
  input  wire logic [7:0]  srcValue,
  input  wire logic [7:0]  stackData,
  // Flags as seen before this instruction
  input  wire logic [7:0]  flagsIn,
  // Results to register file, flags register and stack pointer
  output logic             resultValid,
  output logic             resultWide,
  output logic [15:0]      resultData,
  output logic [7:0]       flagsOut,
  output logic [11:0]      stackPtr,
  output logic             stackPopped
);

  typedef struct packed {
    logic        valid;
    logic        wide;
    logic [15:0] data;
    logic [7:0]  flags;
    logic [11:0] sp;
    logic        popped;
  } lms_state_s;

  lms_state_s stateReg;
  lms_state_s stateNext;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic inRange(input logic [7:0] op, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (op >= lo) && (op <= hi);
  endfunction : inRange

  logic    isOr;
  logic    isXor;
  lms_op_e opKind;
  logic [7:0] logicResult;

  always_comb begin
    isOr  = inRange(opcode, OP_OR_FIRST, OP_OR_LAST)
         || inRange(opcode, OP_OR_EXT_FIRST, OP_OR_EXT_LAST);
    isXor = inRange(opcode, OP_XOR_FIRST, OP_XOR_LAST)
         || inRange(opcode, OP_XOR_EXT_FIRST, OP_XOR_EXT_LAST);
    if (!issueValid) begin
      opKind = LMS_OP_NONE;
    end else if (opcode == OP_MULTIPLY_PAIR) begin
      opKind = LMS_OP_MUL;
    end else if (isOr || isXor) begin
      opKind = LMS_OP_LOG;
    end else if (opcode == OP_POP_DIRECT || opcode == OP_POP_INDIRECT) begin
      opKind = LMS_OP_POP;
    end else begin
      opKind = LMS_OP_NONE;
    end
    logicResult = isOr ? (dstValue[7:0] | srcValue)
                       : (dstValue[7:0] ^ srcValue);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    stateNext        = stateReg;
    stateNext.valid  = 1'b0;
    stateNext.popped = 1'b0;
    // Flags pass through so an unrelated instruction never disturbs them
    stateNext.flags  = flagsIn;
    case (opKind)
      LMS_OP_MUL: begin
        stateNext.valid = 1'b1;
        stateNext.wide  = 1'b1;
        // Operands widened first so the product keeps its upper byte
        stateNext.data  = 16'(dstValue[15:8]) * 16'(dstValue[7:0]);
      end
      LMS_OP_LOG: begin
        stateNext.valid = 1'b1;
        stateNext.wide  = 1'b0;
        stateNext.data  = {8'h00, logicResult};
        // C, D and H keep the incoming value
        stateNext.flags[FLAG_Z] = (logicResult == 8'h00);
        stateNext.flags[FLAG_S] = logicResult[7];
        stateNext.flags[FLAG_V] = 1'b0;
      end
      LMS_OP_POP: begin
        stateNext.valid  = 1'b1;
        stateNext.wide   = 1'b0;
        stateNext.data   = {8'h00, stackData};
        // Pointer wraps silently; stack depth is left to software
        stateNext.sp     = stateReg.sp + 12'h001;
        stateNext.popped = 1'b1;
      end
      default: begin
        stateNext.valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset loads constants only, so the asynchronous path carries no logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateReg <= '{valid: 1'b0, wide: 1'b0, data: WORD_RESET, flags: FLAGS_RESET,
                    sp: SP_RESET, popped: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign resultValid = stateReg.valid;
  assign resultWide  = stateReg.wide;
  assign resultData  = stateReg.data;
  assign flagsOut    = stateReg.flags;
  assign stackPtr    = stateReg.sp;
  assign stackPopped = stateReg.popped;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_mul;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && opcode == OP_MULTIPLY_PAIR) |=>
      resultValid && resultWide
      && resultData == 16'($past(dstValue[15:8])) * 16'($past(dstValue[7:0]));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply result wrong");

  property p_mul_flags;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && opcode == OP_MULTIPLY_PAIR) |=> flagsOut == $past(flagsIn);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");

  property p_or;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && isOr) |=> resultValid
      && resultData[7:0] == ($past(dstValue[7:0]) | $past(srcValue)) && !flagsOut[FLAG_V];
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");

  property p_xor;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && isXor) |=> resultValid
      && resultData[7:0] == ($past(dstValue[7:0]) ^ $past(srcValue)) && !flagsOut[FLAG_V];
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_log_flags;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && (isOr || isXor)) |=>
      flagsOut[FLAG_Z] == (resultData[7:0] == 8'h00) && flagsOut[FLAG_S] == resultData[7]
      && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C]) && flagsOut[FLAG_D] == $past(flagsIn[FLAG_D])
      && flagsOut[FLAG_H] == $past(flagsIn[FLAG_H]);
  endproperty
  a_log_flags: assert property (p_log_flags) else $error("logic flags wrong");

  property p_pop;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && (opcode == OP_POP_DIRECT || opcode == OP_POP_INDIRECT)) |=>
      stackPopped && resultData[7:0] == $past(stackData) && stackPtr == $past(stackPtr) + 12'h001
      && flagsOut == $past(flagsIn);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_sp_hold;
    @(posedge clk) disable iff (sys_rst)
    !(issueValid && (opcode == OP_POP_DIRECT || opcode == OP_POP_INDIRECT)) |=> $stable(stackPtr);
  endproperty
  a_sp_hold: assert property (p_sp_hold) else $error("stack pointer moved");

  property p_idle;
    @(posedge clk) disable iff (sys_rst)
    (opKind == LMS_OP_NONE) |=> !resultValid ##1 1'b1;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious result");

  // Logic results occupy the low byte only; the upper byte must read zero
  property p_log_narrow;
    @(posedge clk) disable iff (sys_rst)
    (issueValid && (isOr || isXor)) |=> !resultWide && resultData[15:8] == 8'h00;
  endproperty
  a_log_narrow: assert property (p_log_narrow) else $error("logic result not narrow");

  // Every instruction but OR and XOR leaves all flags exactly as they were
  property p_flags_pass;
    @(posedge clk) disable iff (sys_rst)
    !(issueValid && (isOr || isXor)) |=> flagsOut == $past(flagsIn);
  endproperty
  a_flags_pass: assert property (p_flags_pass) else $error("unaffected flags changed");

  // Pop in two steps: issue, then a narrow valid result with the pop strobe
  sequence s_popIssue;
    issueValid && (opcode == OP_POP_DIRECT || opcode == OP_POP_INDIRECT);
  endsequence

  sequence s_popDone;
    stackPopped && resultValid && !resultWide;
  endsequence

  property p_pop_steps;
    @(posedge clk) disable iff (sys_rst)
    s_popIssue |=> s_popDone;
  endproperty
  a_pop_steps: assert property (p_pop_steps) else $error("pop did not complete");

  // The pop strobe never stands without a result beside it
  property p_pop_strobe;
    @(posedge clk) disable iff (sys_rst)
    stackPopped |-> resultValid && resultData[15:8] == 8'h00;
  endproperty
  a_pop_strobe: assert property (p_pop_strobe) else $error("pop strobe alone");

endmodule : lms_exec

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import lms_pkg::*;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        issueValid = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [15:0] dstValue = 16'h0000;
  logic [7:0]  srcValue = 8'h00;
  logic [7:0]  stackData = 8'h00;
  logic [7:0]  flagsIn = 8'h00;
  logic        resultValid, resultWide, stackPopped;
  logic [15:0] resultData;
  logic [7:0]  flagsOut;
  logic [11:0] stackPtr;
  logic [11:0] expSp;
  logic [15:0] expData;
  logic        expWide;
  int          failures = 0;
  int          numChecks = 0;
  logic [7:0]  opList [20] = '{8'hF4, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
    8'h49, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'h50, 8'h51, 8'h0F};

  always #4 clk = ~clk;

  lms_exec u_dut (.clk(clk), .sys_rst(sysRst), .issueValid(issueValid), .opcode(opcode),
    .dstValue(dstValue), .srcValue(srcValue), .stackData(stackData), .flagsIn(flagsIn),
    .resultValid(resultValid), .resultWide(resultWide), .resultData(resultData),
    .flagsOut(flagsOut), .stackPtr(stackPtr), .stackPopped(stackPopped));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic bit isOr(input logic [7:0] op);
    return op >= OP_OR_FIRST && op <= OP_OR_EXT_LAST;
  endfunction : isOr

  function automatic bit isXor(input logic [7:0] op);
    return op >= OP_XOR_FIRST && op <= OP_XOR_EXT_LAST;
  endfunction : isXor

  function automatic bit isPop(input logic [7:0] op);
    return op == OP_POP_DIRECT || op == OP_POP_INDIRECT;
  endfunction : isPop

  function automatic logic [15:0] calcData(input logic [7:0] op, input logic [15:0] d,
                                           input logic [7:0] s, input logic [7:0] k);
    if (op == OP_MULTIPLY_PAIR) return 16'(d[15:8]) * 16'(d[7:0]);
    if (isPop(op)) return {8'h00, k};
    return {8'h00, isOr(op) ? (d[7:0] | s) : (d[7:0] ^ s)};
  endfunction : calcData

  task automatic chkData(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask : chkData

  task automatic chkFlags(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask : chkFlags

  task automatic chkSp(input logic [11:0] got, input logic [11:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t sp got=%h exp=%h", $time, got, exp);
    end
  endtask : chkSp

  task automatic chkBit(input logic got, input logic exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t strobe got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit

  task automatic print_verdict();
    if (failures == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Caller stands just after a rising edge; result is checked one edge later
  task automatic doOp(input logic v, input logic [7:0] op, input logic [15:0] d,
                      input logic [7:0] s, input logic [7:0] k, input logic [7:0] f);
    logic       hit;
    logic       lg;
    logic [7:0] ef;
    logic [15:0] ed;
    issueValid = v; opcode = op; dstValue = d; srcValue = s; stackData = k; flagsIn = f;
    hit = v && (op == OP_MULTIPLY_PAIR || isOr(op) || isXor(op) || isPop(op));
    lg = hit && (isOr(op) || isXor(op));
    ed = calcData(op, d, s, k);
    ef = f;
    if (lg) begin
      ef[FLAG_Z] = (ed[7:0] == 8'h00);
      ef[FLAG_S] = ed[7];
      ef[FLAG_V] = 1'b0;
    end
    if (hit && isPop(op)) expSp = expSp + 12'h001;
    // Data and width hold until the next accepted instruction
    if (hit) begin
      expData = ed;
      expWide = (op == OP_MULTIPLY_PAIR);
    end
    @(posedge clk);
    #1;
    chkBit(resultValid, hit);
    chkFlags(flagsOut, ef);
    chkData(resultData, expData);
    chkBit(resultWide, expWide);
    chkSp(stackPtr, expSp);
    chkBit(stackPopped, hit && isPop(op));
  endtask : doOp

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(78));
    expSp = SP_RESET;
    expData = WORD_RESET;
    expWide = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chkBit(resultValid, 1'b0);
    chkBit(resultWide, 1'b0);
    chkBit(stackPopped, 1'b0);
    chkData(resultData, WORD_RESET);
    chkFlags(flagsOut, FLAGS_RESET);
    chkSp(stackPtr, SP_RESET);
    sysRst = 1'b0;
    foreach (opList[i])
      doOp(1'b1, opList[i], 16'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    doOp(1'b1, OP_MULTIPLY_PAIR, 16'hFFFF, 8'h00, 8'h00, 8'hFF);
    doOp(1'b1, OP_MULTIPLY_PAIR, 16'h0304, 8'h00, 8'h00, 8'hF0);
    doOp(1'b1, OP_OR_FIRST, 16'hAB00, 8'h00, 8'h00, 8'hFF);
    doOp(1'b1, OP_XOR_EXT_LAST, 16'h0055, 8'h55, 8'h00, 8'hEC);
    doOp(1'b1, OP_XOR_FIRST, 16'h0000, 8'h80, 8'h00, 8'h10);
    doOp(1'b0, OP_POP_DIRECT, 16'h0000, 8'h00, 8'hAA, 8'h3C);
    repeat (5) doOp(1'b1, OP_POP_INDIRECT, 16'h0000, 8'h00, 8'($urandom), 8'h00);
    repeat (400) doOp(($urandom % 5) != 0, opList[$urandom % 20], 16'($urandom),
                      8'($urandom), 8'($urandom), 8'($urandom));
    // A second reset in mid-run must bring the stack pointer home
    sysRst = 1'b1;
    @(posedge clk);
    #1;
    chkSp(stackPtr, SP_RESET);
    chkBit(resultValid, 1'b0);
    chkData(resultData, WORD_RESET);
    sysRst = 1'b0;
    expSp = SP_RESET;
    expData = WORD_RESET;
    expWide = 1'b0;
    doOp(1'b1, OP_POP_DIRECT, 16'h0000, 8'h00, 8'h5A, 8'h00);
    doOp(1'b1, OP_MULTIPLY_PAIR, 16'h0304, 8'h00, 8'h00, 8'h0F);
    print_verdict();
  end

  initial begin
    #(8 * 3000);
    failures++;
    print_verdict();
  end
endmodule : tb_top
